/* epv_params.svh */
// Constants for the EEPROM program, protection and section verify sequencer.
// Offsets are byte addresses on the register slave; widths are as used by epv_core.
`ifndef EPV_PARAMS_SVH
`define EPV_PARAMS_SVH
// Register byte offsets
`define EPV_OFS_STAT 5'h00
`define EPV_OFS_INDEX 5'h04
`define EPV_OFS_DATA 5'h08
`define EPV_OFS_PROT 5'h0C
`define EPV_OFS_MODE 5'h10
// Status field positions
`define EPV_B_CMD_COMPLETE_FLAG 7
`define EPV_B_ACCESS_ERROR_FLAG 5
`define EPV_B_PROT_VIOLATION_FLAG 4
`define EPV_B_MG1 1
`define EPV_B_MG0 0
// Protection register field positions
`define EPV_B_OPEN 7
// Command codes
`define EPV_CMD_PROG_EE 8'h11
`define EPV_CMD_VFY_PF 8'h03
// Parameter slot indices
`define EPV_IX_W0 3'h2
`define EPV_IX_W3 3'h5
// Protection byte location and region shape
`define EPV_CFG_ADDR 18'h3FF0D
`define EPV_PROT_BASE 18'h00400
`define EPV_PROT_STEP 18'h00020
`define EPV_PROT_MAX 6'h2F
`define EPV_PROT_TOP 18'h009FF
// Reset values and misc
`define EPV_SIZE_RST 6'h3F
`define EPV_MODE_RST 1'h1
`define EPV_ERASED 16'hFFFF
`endif

/* epv_pkg.sv */
// Types shared by the EEPROM program, protection and verify sequencer.
// Assumes epv_params.svh supplies the numeric constants.
package epv_pkg;
  // One-hot sequencer states
  typedef enum logic [4:0] {
    ST_CFG = 5'h01,
    ST_IDLE = 5'h02,
    ST_PROG = 5'h04,
    ST_PCHK = 5'h08,
    ST_VFY = 5'h10
  } epv_state_t;
  // Status flags toward the rest of the controller
  typedef struct packed {
    logic cmd_complete_flag;
    logic access_error_flag;
    logic prot_violation_flag;
    logic mg1;
    logic mg0;
  } epv_flags_t;
  // Array access request, held until done
  typedef struct packed {
    logic req;
    logic wr;
    logic [17:0] addr;
    logic [15:0] wdata;
  } epv_mem_req_t;
  // Array access answer
  typedef struct packed {
    logic done;
    logic [15:0] rdata;
    logic ecc_single;
    logic ecc_double;
  } epv_mem_rsp_t;
  // Whole state of the sequencer
  typedef struct packed {
    epv_state_t st;
    epv_flags_t flags;
    logic [2:0] idx;
    logic [5:0][15:0] prm;
    logic prot_open;
    logic [5:0] prot_size;
    logic prot_all;
    logic locked;
    logic mode_ok;
    logic [17:0] cnt;
    logic [17:0] addr;
    logic [2:0] wsel;
    epv_mem_req_t mem;
    logic wait_r;
    logic [31:0] rdata;
  } epv_regs_t;
endpackage

/* epv_core.sv */
// EEPROM program, protection load and section erase-verify sequencer.
// Assumes an Avalon-MM master on the register side and an array engine
// that answers each held request with a one-cycle done pulse.
`timescale 1ns/100ps
`default_nettype none
`include "epv_params.svh"

// Summary of operation
// - Program EEPROM: code 0x11, block, address slots
// - Slots 2..5 hold words; index sets count
// - Clearing complete flag launches; set when done
// - Each programmed word is read back, checked
// - Protected target: skip, raise protection violation
// - Block erase refused while any sector protected
// - Protection fields loaded from flash at reset
// - Double fault at load: protect whole EEPROM
// - Bit 7 switches protection on or off
// - Size field: 0x400 base, 32-byte steps
// - Sizes 47..63 all cap at 0x9FF
// - Verify section: code 0x03, address, phrase count
// - Verify section, blank fail sets both status
// - Verify: index not 2 gives access error
// - Verify: not allowed in mode, access error
// - Verify: invalid address gives access error
// - Verify: unaligned phrase gives access error
// - Verify: past flash end, access error
// - Verify: read error sets upper, never violation
// - Verify: uncorrectable or blank fail sets lower
module epv_core import epv_pkg::*; #(
  parameter logic [17:0] PF_BASE = 18'h20000,
  parameter logic [17:0] PF_END = 18'h3FFFF,
  parameter logic [17:0] EE_BASE = 18'h00000,
  parameter logic [17:0] EE_END = 18'h013FF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Array engine
  output epv_mem_req_t mem_cmd,
  input wire epv_mem_rsp_t mem_rsp,
  // Status toward the controller
  output epv_flags_t flash_flags,
  output logic ee_erase_locked
);

  // ==========================================================
  // Parameter checks
  if (EE_END <= EE_BASE || PF_END <= PF_BASE) begin : g_bad
    $error("epv_core: address ranges are empty");
  end

  // ==========================================================
  // Helpers
  // Last byte covered by the protection region for a size value
  function automatic logic [17:0] prot_end(input logic [5:0] sz);
    logic [5:0] s;
    s = (sz > `EPV_PROT_MAX) ? `EPV_PROT_MAX : sz;
    prot_end = 18'(`EPV_PROT_BASE + 18'({12'h0, s} + 18'h1) * `EPV_PROT_STEP
      - 18'h1);
  endfunction

  // True when byte range lo..hi touches a protected location
  function automatic logic prot_hit(input logic [17:0] lo, input logic [17:0] hi,
    input logic open, input logic all_p, input logic [5:0] sz);
    logic [17:0] b;
    logic [17:0] e;
    b = all_p ? EE_BASE : `EPV_PROT_BASE;
    e = all_p ? EE_END : prot_end(sz);
    // Open bit high lifts protection entirely
    prot_hit = !open && lo <= e && hi >= b;
  endfunction

  // ==========================================================
  // State and decode terms
  epv_regs_t q; // Registered state
  epv_regs_t d; // Next state
  logic req; // Bus request present
  logic acc; // Bus request accepted this edge
  logic launch; // Command launch write accepted
  logic dn; // Array answer for our request
  logic [7:0] cmd; // Command code in slot 0
  logic [17:0] a; // Global start address
  logic [2:0] pn; // Words to program
  logic [18:0] p_last; // Last byte of program range
  logic [18:0] v_last; // Last byte of verify range
  logic p_idx_bad; // Program index out of range
  logic p_addr_bad; // Program address unusable
  logic p_prot; // Program hits protection
  logic v_bad; // Verify launch refused
  logic [7:0] cfg_byte; // Protection byte out of the read word
  // Named copy so single bits can be picked; a bare literal allows no select
  localparam logic [17:0] CFG_ADDR = `EPV_CFG_ADDR;

  assign req = avs_read | avs_write;
  assign acc = req & ~q.wait_r;
  assign dn = mem_rsp.done & q.mem.req;
  assign cmd = q.prm[0][15:8];
  assign a = {q.prm[0][1:0], q.prm[1]};
  assign pn = 3'(q.idx - 3'h1);
  assign p_last = {1'b0, a} + {15'h0, pn, 1'b0} - 19'h1;
  assign v_last = {1'b0, a} + {q.prm[2], 3'h0} - 19'h1;
  // Index value at launch decides the word count
  assign p_idx_bad = q.idx < `EPV_IX_W0 || q.idx > `EPV_IX_W3;
  assign p_addr_bad = a[0] || a < EE_BASE || p_last > {1'b0, EE_END};
  assign p_prot = prot_hit(a, p_last[17:0], q.prot_open, q.prot_all,
    q.prot_size);
  assign v_bad = q.idx != `EPV_IX_W0
    || !q.mode_ok
    || a < PF_BASE || a > PF_END
    || a[2:0] != 3'h0
    || q.prm[2] == 16'h0
    || v_last > {1'b0, PF_END};
  // Odd byte address picks the low byte of the word
  assign cfg_byte = CFG_ADDR[0] ? mem_rsp.rdata[7:0] : mem_rsp.rdata[15:8];

  always_comb begin
    // Launch needs an idle sequencer and no pending error flag
    launch = acc && avs_write && avs_address == `EPV_OFS_STAT && avs_byteenable[0]
      && avs_writedata[`EPV_B_CMD_COMPLETE_FLAG] && q.flags.cmd_complete_flag && q.st == ST_IDLE
      && !q.flags.access_error_flag && !q.flags.prot_violation_flag;
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    d = q;
    // One wait cycle per access; read data staged during it
    d.wait_r = ~(req & q.wait_r);
    if (req && q.wait_r) begin
      case (avs_address)
        `EPV_OFS_STAT: begin
          d.rdata = {24'h0, q.flags.cmd_complete_flag, 1'b0, q.flags.access_error_flag, q.flags.prot_violation_flag,
            2'h0, q.flags.mg1, q.flags.mg0};
        end
        `EPV_OFS_INDEX: begin
          d.rdata = {29'h0, q.idx};
        end
        `EPV_OFS_DATA: begin
          d.rdata = (q.idx <= `EPV_IX_W3) ? {16'h0, q.prm[q.idx]} : 32'h0;
        end
        `EPV_OFS_PROT: begin
          d.rdata = {24'h0, q.prot_open, 1'b0, q.prot_size};
        end
        `EPV_OFS_MODE: begin
          d.rdata = {31'h0, q.mode_ok};
        end
        default: begin
          d.rdata = 32'h0; // Unmapped reads as zero
        end
      endcase
    end
    // Register writes; clears come first so hardware sets win
    if (acc && avs_write) begin
      case (avs_address)
        `EPV_OFS_STAT: begin
          if (avs_byteenable[0] && avs_writedata[`EPV_B_ACCESS_ERROR_FLAG]) begin
            d.flags.access_error_flag = 1'b0;
          end
          if (avs_byteenable[0] && avs_writedata[`EPV_B_PROT_VIOLATION_FLAG]) begin
            d.flags.prot_violation_flag = 1'b0;
          end
        end
        `EPV_OFS_INDEX: begin
          // Parameters only change while no command runs
          if (avs_byteenable[0] && q.flags.cmd_complete_flag) begin
            d.idx = avs_writedata[2:0];
          end
        end
        `EPV_OFS_DATA: begin
          if (q.flags.cmd_complete_flag && q.idx <= `EPV_IX_W3) begin
            if (avs_byteenable[0]) begin
              d.prm[q.idx][7:0] = avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
              d.prm[q.idx][15:8] = avs_writedata[15:8];
            end
          end
        end
        `EPV_OFS_MODE: begin
          if (avs_byteenable[0]) begin
            d.mode_ok = avs_writedata[0];
          end
        end
        default: begin
          d.mode_ok = q.mode_ok; // Unmapped writes ignored
        end
      endcase
    end
    // Sequencer
    case (q.st)
      ST_CFG: begin
        // Fetch the protection byte before any command is taken
        d.mem = '{req: ~dn, wr: 1'b0, addr: {CFG_ADDR[17:1], 1'b0}, wdata: 16'h0};
        if (dn) begin
          if (mem_rsp.ecc_double) begin
            d.prot_open = 1'b0;
            d.prot_size = `EPV_SIZE_RST;
            d.prot_all = 1'b1;
          end else begin
            d.prot_open = cfg_byte[`EPV_B_OPEN];
            d.prot_size = cfg_byte[5:0];
            d.prot_all = 1'b0;
          end
          d.flags.cmd_complete_flag = 1'b1;
          d.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (launch) begin
          d.flags.cmd_complete_flag = 1'b0;
          d.flags.mg1 = 1'b0;
          d.flags.mg0 = 1'b0;
          if (cmd == `EPV_CMD_PROG_EE) begin
            if (p_idx_bad || p_addr_bad) begin
              d.flags.access_error_flag = 1'b1;
              d.flags.cmd_complete_flag = 1'b1;
            end else if (p_prot) begin
              d.flags.prot_violation_flag = 1'b1;
              d.flags.cmd_complete_flag = 1'b1;
            end else begin
              d.st = ST_PROG;
              d.addr = a;
              d.cnt = {15'h0, pn};
              d.wsel = `EPV_IX_W0;
            end
          end else if (cmd == `EPV_CMD_VFY_PF) begin
            if (v_bad) begin
              d.flags.access_error_flag = 1'b1;
              d.flags.cmd_complete_flag = 1'b1;
            end else begin
              d.st = ST_VFY;
              d.addr = a;
              d.cnt = {q.prm[2], 2'h0};
            end
          end else begin
            // Commands outside this block are refused here
            d.flags.access_error_flag = 1'b1;
            d.flags.cmd_complete_flag = 1'b1;
          end
        end
      end
      ST_PROG: begin
        d.mem = '{req: ~dn, wr: 1'b1, addr: q.addr, wdata: q.prm[q.wsel]};
        if (dn) begin
          d.st = ST_PCHK;
        end
      end
      ST_PCHK: begin
        // Read back what was just written
        d.mem = '{req: ~dn, wr: 1'b0, addr: q.addr, wdata: 16'h0};
        if (dn) begin
          if (mem_rsp.ecc_double || mem_rsp.rdata != q.prm[q.wsel]) begin
            d.flags.mg1 = 1'b1;
            d.flags.mg0 = 1'b1;
          end
          d.addr = q.addr + 18'h2;
          d.wsel = q.wsel + 3'h1;
          d.cnt = q.cnt - 18'h1;
          if (q.cnt == 18'h1) begin
            d.flags.cmd_complete_flag = 1'b1;
            d.st = ST_IDLE;
          end else begin
            d.st = ST_PROG;
          end
        end
      end
      ST_VFY: begin
        d.mem = '{req: ~dn, wr: 1'b0, addr: q.addr, wdata: 16'h0};
        if (dn) begin
          // Violation flag is never touched on this path
          if (mem_rsp.ecc_single || mem_rsp.ecc_double) begin
            d.flags.mg1 = 1'b1;
          end
          if (mem_rsp.ecc_double || mem_rsp.rdata != `EPV_ERASED) begin
            d.flags.mg0 = 1'b1;
          end
          if (mem_rsp.rdata != `EPV_ERASED) begin
            d.flags.mg1 = 1'b1;
          end
          d.addr = q.addr + 18'h2;
          d.cnt = q.cnt - 18'h1;
          if (q.cnt == 18'h1) begin
            d.flags.cmd_complete_flag = 1'b1;
            d.st = ST_IDLE;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // Any closed protection blocks a full erase
    d.locked = !d.prot_open;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Fully protected until the flash byte arrives
      q <= '{st: ST_CFG, prot_size: `EPV_SIZE_RST, prot_all: 1'b1, locked: 1'b1,
        mode_ok: `EPV_MODE_RST, wait_r: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.wait_r;
  assign mem_cmd = q.mem;
  assign flash_flags = q.flags;
  assign ee_erase_locked = q.locked;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_prog_ok;
    launch && cmd == `EPV_CMD_PROG_EE && !p_idx_bad && !p_addr_bad && !p_prot;
  endsequence
  sequence s_vfy_go;
    launch && cmd == `EPV_CMD_VFY_PF && !v_bad;
  endsequence
  sequence s_last_read;
    q.st == ST_VFY && dn && q.cnt == 18'h1;
  endsequence

  AST_BUS_ONE_WAIT: assert property (req && q.wait_r |=> !avs_waitrequest)
    else $error("bus answer not after one wait");
  AST_PROG_COUNT: assert property (s_prog_ok |=> q.st == ST_PROG
    && q.cnt == {15'h0, $past(pn)} && q.wsel == `EPV_IX_W0)
    else $error("program word count wrong");
  AST_LAUNCH_BUSY: assert property (s_prog_ok or s_vfy_go |=> !flash_flags.cmd_complete_flag)
    else $error("complete flag not cleared on launch");
  AST_READBACK: assert property (q.st == ST_PROG && dn |=> q.st == ST_PCHK
    ##[1:1000] q.st == ST_PCHK && dn)
    else $error("written word not read back");
  AST_PROT_VIOL: assert property (launch && cmd == `EPV_CMD_PROG_EE && !p_idx_bad
    && !p_addr_bad && p_prot |=> flash_flags.prot_violation_flag && flash_flags.cmd_complete_flag
    && q.st == ST_IDLE)
    else $error("protected program not refused");
  AST_ERASE_LOCK: assert property (q.st == ST_IDLE && $past(q.st) == ST_IDLE
    |-> ee_erase_locked == !q.prot_open)
    else $error("erase lock disagrees with protection");
  AST_CFG_LOAD: assert property (q.st == ST_CFG && dn && !mem_rsp.ecc_double
    |=> q.prot_open == $past(cfg_byte[7]) && q.prot_size == $past(cfg_byte[5:0]))
    else $error("protection byte not loaded");
  AST_CFG_FAULT: assert property (q.st == ST_CFG && dn && mem_rsp.ecc_double
    |=> !q.prot_open && q.prot_all ##1 ee_erase_locked)
    else $error("fault did not protect whole EEPROM");
  AST_SIZE_CAP: assert property (prot_end(q.prot_size) <= `EPV_PROT_TOP)
    else $error("protection region beyond cap");
  AST_VFY_DONE: assert property (s_last_read |=> flash_flags.cmd_complete_flag && q.st == ST_IDLE)
    else $error("verify did not complete");
  AST_VFY_INDEX: assert property (launch && cmd == `EPV_CMD_VFY_PF
    && q.idx != `EPV_IX_W0 |=> flash_flags.access_error_flag && q.st == ST_IDLE)
    else $error("verify index error not flagged");
  AST_VFY_ALIGN: assert property (launch && cmd == `EPV_CMD_VFY_PF
    && a[2:0] != 3'h0 |=> flash_flags.access_error_flag)
    else $error("misaligned verify not flagged");
  AST_VFY_NO_VIOL: assert property (q.st == ST_VFY |=> !$rose(flash_flags.prot_violation_flag))
    else $error("violation raised during verify");

endmodule
`default_nettype wire

/* tb_eeprom_program_protect_verify.sv */
// Self-checking bench for the EEPROM program, protection and section verify sequencer.
// Assumes epv_pkg and epv_core are compiled first; the bench is bus master and array.
`timescale 1ns/100ps
`default_nettype none
`include "epv_params.svh"
module tb_eeprom_program_protect_verify import epv_pkg::*;;
  // ==========================================================
  // Signals
  logic clk;
  logic rst_n;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  epv_mem_req_t mem_cmd;
  epv_mem_rsp_t mem_rsp;
  epv_flags_t flash_flags;
  logic ee_erase_locked;
  int n_mismatch; // Failed comparisons
  int n_tests; // All comparisons
  int n_wr; // Array writes seen
  int dly; // Array answer delay
  logic [7:0] cfg_byte; // Protection byte held in flash
  logic cfg_dbe; // Double fault on the byte read
  logic corrupt; // Spoil program readback
  logic [17:0] bad_addr; // Non-erased verify word
  logic [17:0] sgl_addr; // Corrected-fault verify word
  logic [15:0] last_wd; // Last programmed word
  logic [17:0] last_wa; // Last programmed address
  logic [31:0] rd; // Last bus read
  // ==========================================================
  // Device under test
  epv_core u_epv_core (
    .clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_cmd(mem_cmd), .mem_rsp(mem_rsp),
    .flash_flags(flash_flags), .ee_erase_locked(ee_erase_locked)
  );
  // ==========================================================
  // Clock, start values, watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Whole run is a few thousand cycles; this is ample
  initial begin
    #(8 * 40000);
    n_mismatch++;
    test_done;
  end
  // ==========================================================
  // Array model: answers each held request after three cycles
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Cleared with the device so no stale answer survives a reset
      mem_rsp <= '0;
      dly <= 0;
      n_wr <= 0;
      last_wd <= 16'h0000;
      last_wa <= 18'h00000;
    end else begin
      // Skip the done cycle itself so one request gets one answer
      mem_rsp.done <= mem_cmd.req && !mem_rsp.done && dly >= 2;
      if (mem_cmd.req && !mem_rsp.done) begin
        if (dly < 2) begin
          dly <= dly + 1;
        end else begin
          dly <= 0;
          mem_rsp.ecc_double <= cfg_dbe && (mem_cmd.addr == 18'h3FF0C);
          mem_rsp.ecc_single <= (mem_cmd.addr == sgl_addr);
          if (mem_cmd.wr) begin
            n_wr <= n_wr + 1;
            last_wd <= mem_cmd.wdata;
            last_wa <= mem_cmd.addr;
          end
          if (mem_cmd.addr == 18'h3FF0C) begin
            mem_rsp.rdata <= {8'hFF, cfg_byte};
          end else if (mem_cmd.addr < 18'h20000) begin
            mem_rsp.rdata <= last_wd ^ {15'h0000, corrupt};
          end else begin
            mem_rsp.rdata <= (mem_cmd.addr == bad_addr) ? 16'h0000 : `EPV_ERASED;
          end
        end
      end
    end
  end
  // ==========================================================
  // Shared tasks
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      $display("FAIL %0t bus hang", $time);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Wait for the complete flag; it drops one cycle after a launch
  task automatic wait_cc;
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (flash_flags.cmd_complete_flag !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      n_mismatch++;
      $display("FAIL %0t complete flag never set", $time);
    end
  endtask
  // Load all six slots, set the index, launch, judge flags and writes
  // Scenarios only program fresh erased words, never one twice
  task automatic run(input logic [7:0] code, input logic [17:0] a, input logic [2:0] ix,
      input logic [15:0] p2, input logic [4:0] exp_f, input int exp_w);
    int w0;
    logic [15:0] v;
    w0 = n_wr;
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? {code, 6'h00, a[17:16]} : (i == 1) ? a[15:0] : p2 + 16'(i - 2);
      bus(1'b1, `EPV_OFS_INDEX, 32'(i));
      bus(1'b1, `EPV_OFS_DATA, {16'h0000, v});
    end
    bus(1'b1, `EPV_OFS_INDEX, {29'h0, ix});
    bus(1'b1, `EPV_OFS_STAT, 32'h00000080);
    wait_cc;
    chk({27'h0, flash_flags}, {27'h0, exp_f}, "flags");
    chk(32'(n_wr - w0), 32'(exp_w), "words");
    if (exp_w > 0) begin
      chk({16'h0, last_wd}, {16'h0, p2 + 16'(exp_w - 1)}, "data");
      chk({14'h0, last_wa}, {14'h0, a + 18'(2 * (exp_w - 1))}, "address");
    end
    // Same flags as seen by software through the status register
    bus(1'b0, `EPV_OFS_STAT, 32'h0);
    chk(rd, {24'h0, exp_f[4], 1'b0, exp_f[3:2], 2'h0, exp_f[1:0]}, "status");
    bus(1'b1, `EPV_OFS_STAT, 32'h00000030);
  endtask
  // Reset for 12 cycles with a given protection byte, then check the load
  task automatic boot(input logic [7:0] b, input logic dbe, input logic [31:0] exp_p);
    cfg_byte = b;
    cfg_dbe = dbe;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wait_cc;
    bus(1'b0, `EPV_OFS_PROT, 32'h0);
    chk(rd, exp_p, "prot");
    chk({31'h0, ee_erase_locked}, {31'h0, ~exp_p[7]}, "erase lock");
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  // Program path under a small protected region
  task automatic t_program;
    boot(8'h02, 1'b0, 32'h00000002);
    run(8'h11, 18'h00000, 3'h5, 16'hA5A0, 5'h10, 4);
    run(8'h11, 18'h00460, 3'h2, 16'h1234, 5'h10, 1);
    run(8'h11, 18'h0045E, 3'h3, 16'h1234, 5'h14, 0);
    run(8'h11, 18'h00100, 3'h6, 16'h1234, 5'h18, 0);
    run(8'h11, 18'h00100, 3'h1, 16'h1234, 5'h18, 0);
    corrupt = 1'b1;
    run(8'h11, 18'h00010, 3'h2, 16'h5555, 5'h13, 1);
    corrupt = 1'b0;
  endtask
  // Section verify: clean, blank fail, corrected fault, refusals
  task automatic t_verify;
    run(8'h03, 18'h20000, 3'h2, 16'h0002, 5'h10, 0);
    bad_addr = 18'h20006;
    run(8'h03, 18'h20000, 3'h2, 16'h0002, 5'h13, 0);
    bad_addr = 18'h3FFFF;
    sgl_addr = 18'h20008;
    run(8'h03, 18'h20000, 3'h2, 16'h0002, 5'h12, 0);
    sgl_addr = 18'h3FFFF;
    run(8'h03, 18'h20000, 3'h3, 16'h0002, 5'h18, 0);
    bus(1'b1, `EPV_OFS_MODE, 32'h00000000);
    run(8'h03, 18'h20000, 3'h2, 16'h0002, 5'h18, 0);
    bus(1'b1, `EPV_OFS_MODE, 32'h00000001);
    run(8'h03, 18'h10000, 3'h2, 16'h0002, 5'h18, 0);
    run(8'h03, 18'h20004, 3'h2, 16'h0002, 5'h18, 0);
    run(8'h03, 18'h3FFF8, 3'h2, 16'h0002, 5'h18, 0);
  endtask
  // Faulty byte read: whole EEPROM stays closed
  task automatic t_load_fault;
    boot(8'h82, 1'b1, 32'h0000003F);
    run(8'h11, 18'h01000, 3'h2, 16'h1234, 5'h14, 0);
  endtask
  // Largest size 63 stops at the capped top address 0x9FF
  task automatic t_size_cap;
    boot(8'h3F, 1'b0, 32'h0000003F);
    run(8'h11, 18'h009FE, 3'h2, 16'h1234, 5'h14, 0);
    run(8'h11, 18'h00A00, 3'h2, 16'h1234, 5'h10, 1);
  endtask
  // Control bit set: protection off
  task automatic t_prot_off;
    boot(8'h80, 1'b0, 32'h00000080);
    run(8'h11, 18'h00400, 3'h2, 16'h1234, 5'h10, 1);
  endtask
  // Start values live here only, so nothing races them at time zero
  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h3;
    avs_writedata = 32'h0;
    n_mismatch = 0;
    n_tests = 0;
    cfg_byte = 8'h00;
    cfg_dbe = 1'b0;
    corrupt = 1'b0;
    bad_addr = 18'h3FFFF;
    sgl_addr = 18'h3FFFF;
    t_program;
    t_verify;
    t_load_fault;
    t_size_cap;
    t_prot_off;
    test_done;
  end
endmodule
`default_nettype wire
